/* rtl/gttb_top.sv */
// General timer time base: clock source select, prescaler and counter.
// Assumes all pin and trigger inputs are already synchronous to MCLK_I
// and that MCLK_I is the timer kernel clock (40 MHz).
//
// Implementation choices: the register offsets and the Avalon-MM register port.
module gttb_top #(
  parameter int CNT_W = 16,
  parameter int FILT_LEN = gttb_pkg::ETI_FILTER_LEN
) (
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [3:0] ITI_I,
  input wire logic CH0_PIN_I,
  input wire logic CH1_PIN_I,
  input wire logic ETI_I,
  output logic UPDATE_O,
  output logic DIR_O,
  output logic [CNT_W-1:0] COUNTER_O
);
  // ****************************************
  // Byte lane merge
  // ****************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  logic ack_q;
  logic wr_ok;
  logic rd_go;
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic run_q;
  logic suppress_q;
  logic dir_q;
  logic [1:0] cam_q;
  logic [2:0] sms_q;
  logic [2:0] trg_q;
  logic ecm1_q;
  logic fall_q;
  logic flag_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] psc_pre_q;
  logic [CNT_W-1:0] psc_sh_q;
  logic [CNT_W-1:0] psc_cnt_q;
  logic [CNT_W-1:0] arr_pre_q;
  logic [CNT_W-1:0] arr_sh_q;
  logic [3:0] iti_prev_q;
  logic ch0_prev_q;
  logic ch1_prev_q;
  logic [FILT_LEN-1:0] eti_hist_q;
  logic eti_filt_q;
  logic eti_prev_q;
  logic upd_q;
  logic [31:0] ctrl_w;
  logic [31:0] slave_w;
  logic [31:0] wdata;
  logic sw_upd;
  logic src_tick;
  logic cnt_tick;
  logic hw_evt;
  logic upd_evt;
  logic center;
  logic eti_rise;
  logic ch0_any;
  logic ch0_sel;
  logic ch1_sel;

  // ****************************************
  // Avalon-MM slave, one wait cycle per access
  // ****************************************
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign wr_ok = AVS_WRITE_I & ack_q;
  assign rd_go = AVS_READ_I & ~ack_q;

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    end
  end

  assign ctrl_w = 32'(run_q) << gttb_pkg::CTRL_RUN
                | 32'(suppress_q) << gttb_pkg::CTRL_SUPPRESS
                | 32'(dir_q) << gttb_pkg::CTRL_DIR
                | 32'(cam_q) << gttb_pkg::CTRL_CAM_LO;
  assign slave_w = 32'(sms_q) << gttb_pkg::SLV_SMS_LO
                 | 32'(trg_q) << gttb_pkg::SLV_TRG_LO
                 | 32'(ecm1_q) << gttb_pkg::SLV_ECM1
                 | 32'(fall_q) << gttb_pkg::SLV_FALL;

  always_comb
  begin
    if (AVS_ADDRESS_I == gttb_pkg::OFS_CTRL)
      rd_d = ctrl_w;
    else if (AVS_ADDRESS_I == gttb_pkg::OFS_SLAVE)
      rd_d = slave_w;
    else if (AVS_ADDRESS_I == gttb_pkg::OFS_STATUS)
      rd_d = 32'(flag_q) << gttb_pkg::STAT_UPD;
    else if (AVS_ADDRESS_I == gttb_pkg::OFS_COUNT)
      rd_d = 32'(cnt_q);
    else if (AVS_ADDRESS_I == gttb_pkg::OFS_PRESC)
      rd_d = 32'(psc_pre_q);
    else if (AVS_ADDRESS_I == gttb_pkg::OFS_RELOAD)
      rd_d = 32'(arr_pre_q);
    else
      rd_d = 32'h0000_0000;
  end

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rd_q <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rd_q <= rd_d;
    end
  end
  assign AVS_READDATA_O = rd_q;

  // ****************************************
  // Control registers
  // ****************************************
  always_comb
  begin
    if (AVS_ADDRESS_I == gttb_pkg::OFS_CTRL)
      wdata = be_merge(ctrl_w, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
    else
      wdata = be_merge(slave_w, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  end

  assign center = cam_q != gttb_pkg::CAM_EDGE;

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      run_q <= 1'b0;
      suppress_q <= 1'b0;
      cam_q <= gttb_pkg::CAM_EDGE;
      sms_q <= gttb_pkg::SMS_INTERNAL;
      trg_q <= 3'h0;
      ecm1_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_CTRL)
    begin
      run_q <= wdata[gttb_pkg::CTRL_RUN];
      suppress_q <= wdata[gttb_pkg::CTRL_SUPPRESS];
      cam_q <= wdata[gttb_pkg::CTRL_CAM_HI:gttb_pkg::CTRL_CAM_LO];
    end
    else if (wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_SLAVE)
    begin
      sms_q <= wdata[gttb_pkg::SLV_SMS_HI:gttb_pkg::SLV_SMS_LO];
      trg_q <= wdata[gttb_pkg::SLV_TRG_HI:gttb_pkg::SLV_TRG_LO];
      ecm1_q <= wdata[gttb_pkg::SLV_ECM1];
      fall_q <= wdata[gttb_pkg::SLV_FALL];
    end
  end

  // Preload values; shadows follow only on an update event
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      psc_pre_q <= gttb_pkg::RST_ZERO;
      arr_pre_q <= gttb_pkg::RST_RELOAD;
    end
    else if (wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_PRESC)
    begin
      psc_pre_q <= CNT_W'(be_merge(32'(psc_pre_q), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
    end
    else if (wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_RELOAD)
    begin
      arr_pre_q <= CNT_W'(be_merge(32'(arr_pre_q), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
    end
  end

  assign sw_upd = wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_EVGEN
                  && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[gttb_pkg::EVG_UPD];

  // ****************************************
  // Clock source selection
  // ****************************************
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      iti_prev_q <= 4'h0;
      ch0_prev_q <= 1'b0;
      ch1_prev_q <= 1'b0;
      eti_hist_q <= '0;
      eti_filt_q <= 1'b0;
      eti_prev_q <= 1'b0;
    end
    else
    begin
      iti_prev_q <= ITI_I;
      ch0_prev_q <= CH0_PIN_I;
      ch1_prev_q <= CH1_PIN_I;
      eti_hist_q <= {eti_hist_q[FILT_LEN-2:0], ETI_I};
      // The filtered level moves only after FILT_LEN agreeing samples
      if (&eti_hist_q)
        eti_filt_q <= 1'b1;
      else if (~|eti_hist_q)
        eti_filt_q <= 1'b0;
      eti_prev_q <= eti_filt_q;
    end
  end

  assign eti_rise = eti_filt_q & ~eti_prev_q;
  assign ch0_any = CH0_PIN_I ^ ch0_prev_q;
  assign ch0_sel = ch0_any & (CH0_PIN_I ^ fall_q);
  assign ch1_sel = (CH1_PIN_I ^ ch1_prev_q) & (CH1_PIN_I ^ fall_q);

  always_comb
  begin
    if (ecm1_q)
      src_tick = eti_rise;
    else if (sms_q == gttb_pkg::SMS_INTERNAL)
      src_tick = 1'b1;
    else if (sms_q >= gttb_pkg::SMS_FIRST_KERNEL && sms_q <= gttb_pkg::SMS_LAST_KERNEL)
      src_tick = 1'b1;
    else
    begin
      // Slave modes 1, 2, 3 and 7 take the trigger-selected source
      case (trg_q)
        gttb_pkg::TRG_CH0_BOTH: src_tick = ch0_any;
        gttb_pkg::TRG_CH0_EDGE: src_tick = ch0_sel;
        gttb_pkg::TRG_CH1_EDGE: src_tick = ch1_sel;
        gttb_pkg::TRG_ETI: src_tick = eti_rise;
        default: src_tick = ITI_I[trg_q[1:0]] & ~iti_prev_q[trg_q[1:0]];
      endcase
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  assign cnt_tick = run_q && src_tick && psc_cnt_q >= psc_sh_q;

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      psc_cnt_q <= gttb_pkg::RST_ZERO;
    end
    else if (sw_upd || upd_evt)
    begin
      psc_cnt_q <= gttb_pkg::RST_ZERO;
    end
    else if (run_q && src_tick)
    begin
      if (psc_cnt_q >= psc_sh_q)
        psc_cnt_q <= gttb_pkg::RST_ZERO;
      else
        psc_cnt_q <= psc_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      psc_sh_q <= gttb_pkg::RST_ZERO;
      arr_sh_q <= gttb_pkg::RST_RELOAD;
    end
    else if (upd_evt)
    begin
      psc_sh_q <= psc_pre_q;
      arr_sh_q <= arr_pre_q;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  always_comb
  begin
    hw_evt = 1'b0;
    if (cnt_tick)
    begin
      if (center)
        hw_evt = dir_q ? (cnt_q <= CNT_W'(1)) : (cnt_q >= arr_sh_q - 1'b1);
      else if (dir_q)
        hw_evt = cnt_q == gttb_pkg::RST_ZERO;
      else
        hw_evt = cnt_q >= arr_sh_q;
    end
  end

  assign upd_evt = (hw_evt || sw_upd) && !suppress_q;

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      cnt_q <= gttb_pkg::RST_ZERO;
    end
    else if (wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_COUNT)
    begin
      cnt_q <= CNT_W'(be_merge(32'(cnt_q), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
    end
    else if (sw_upd)
    begin
      // Software restart; the counter is cleared, or reloaded in edge down mode, even when events are suppressed
      if (!center && dir_q)
        cnt_q <= arr_pre_q;
      else
        cnt_q <= gttb_pkg::RST_ZERO;
    end
    else if (cnt_tick)
    begin
      if (center)
      begin
        if (dir_q && cnt_q <= CNT_W'(1))
          cnt_q <= gttb_pkg::RST_ZERO;
        else if (!dir_q && cnt_q >= arr_sh_q - 1'b1)
          cnt_q <= arr_sh_q;
        else if (dir_q)
          cnt_q <= cnt_q - 1'b1;
        else
          cnt_q <= cnt_q + 1'b1;
      end
      else if (dir_q)
        cnt_q <= (cnt_q == gttb_pkg::RST_ZERO) ? arr_sh_q : cnt_q - 1'b1;
      else
        cnt_q <= (cnt_q >= arr_sh_q) ? gttb_pkg::RST_ZERO : cnt_q + 1'b1;
    end
  end

  // Direction is software-owned in edge mode, hardware-owned in center mode
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      dir_q <= 1'b0;
    end
    else if (center)
    begin
      if (sw_upd)
        dir_q <= 1'b0;
      else if (cnt_tick && dir_q && cnt_q <= CNT_W'(1))
        dir_q <= 1'b0;
      else if (cnt_tick && !dir_q && cnt_q >= arr_sh_q - 1'b1)
        dir_q <= 1'b1;
    end
    else if (wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_CTRL)
    begin
      dir_q <= wdata[gttb_pkg::CTRL_DIR];
    end
  end

  // ****************************************
  // Update flag and outputs
  // ****************************************
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      flag_q <= 1'b0;
      upd_q <= 1'b0;
    end
    else
    begin
      upd_q <= upd_evt;
      // A new event in the clearing cycle keeps the flag set
      if (upd_evt)
        flag_q <= 1'b1;
      else if (wr_ok && AVS_ADDRESS_I == gttb_pkg::OFS_STATUS && AVS_BYTEENABLE_I[0]
               && !AVS_WRITEDATA_I[gttb_pkg::STAT_UPD])
        flag_q <= 1'b0;
    end
  end

  assign UPDATE_O = upd_q;
  assign DIR_O = dir_q;
  assign COUNTER_O = cnt_q;
endmodule : gttb_top

/* rtl/gttb_pkg.sv */
// Shared constants of the general timer time base.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package gttb_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLAVE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVGEN = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_PRESC = 8'h14;
  localparam logic [7:0] OFS_RELOAD = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SUPPRESS = 1;
  localparam int CTRL_DIR = 4;
  localparam int CTRL_CAM_LO = 5;
  localparam int CTRL_CAM_HI = 6;
  localparam int SLV_SMS_LO = 0;
  localparam int SLV_SMS_HI = 2;
  localparam int SLV_TRG_LO = 4;
  localparam int SLV_TRG_HI = 6;
  localparam int SLV_ECM1 = 14;
  localparam int SLV_FALL = 15;
  localparam int STAT_UPD = 0;
  localparam int EVG_UPD = 0;
  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [15:0] RST_RELOAD = 16'hffff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [2:0] SMS_INTERNAL = 3'h0;
  localparam logic [2:0] SMS_EXT_MODE0 = 3'h7;
  localparam logic [2:0] SMS_FIRST_KERNEL = 3'h4;
  localparam logic [2:0] SMS_LAST_KERNEL = 3'h6;
  localparam logic [2:0] TRG_LAST_ITI = 3'h3;
  localparam logic [2:0] TRG_CH0_BOTH = 3'h4;
  localparam logic [2:0] TRG_CH0_EDGE = 3'h5;
  localparam logic [2:0] TRG_CH1_EDGE = 3'h6;
  localparam logic [2:0] TRG_ETI = 3'h7;
  localparam logic [1:0] CAM_EDGE = 2'h0;
  localparam int ETI_FILTER_LEN = 4;
endpackage : gttb_pkg

/* test/gttb_chk.sv */
// Port-level checks of the timer time base.
// Assumes software never writes the counter register directly.
module gttb_chk #(
  parameter int CNT_W = 16
) (
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic UPDATE_O,
  input wire logic DIR_O,
  input wire logic [CNT_W-1:0] COUNTER_O
);
  // ****
  // Bus and counter properties
  // ****
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);
  logic req;
  assign req = AVS_READ_I | AVS_WRITE_I;
  chk_wait_idle: assert property (!req |-> !AVS_WAITREQUEST_O)
    else $error("waitrequest while idle");
  chk_wait_one: assert property ($rose(req) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("wait not exactly one cycle");
  chk_back_wait: assert property (req && !AVS_WAITREQUEST_O ##1 req |-> AVS_WAITREQUEST_O)
    else $error("next request got no wait");
  // Writes are excluded since software update may move the counter anywhere
  chk_cnt_up: assert property (!DIR_O && $stable(DIR_O) && !$past(AVS_WRITE_I)
    && $changed(COUNTER_O) |-> COUNTER_O == $past(COUNTER_O) + 1'b1 || COUNTER_O == '0)
    else $error("up step wrong");
  chk_cnt_down: assert property (DIR_O && $stable(DIR_O) && !$past(AVS_WRITE_I)
    && $changed(COUNTER_O) && $past(COUNTER_O) != '0 |-> COUNTER_O == $past(COUNTER_O) - 1'b1)
    else $error("down step wrong");
  chk_upd_cause: assert property ($rose(UPDATE_O) |-> $changed(COUNTER_O)
    || $past(AVS_WRITE_I))
    else $error("update without count step");
  chk_upd_zero: assert property (UPDATE_O && !DIR_O && !$past(AVS_WRITE_I)
    |-> COUNTER_O == '0)
    else $error("up event not at zero");
  chk_upd_down: assert property (UPDATE_O && DIR_O && $past(DIR_O)
    && !$past(AVS_WRITE_I) |-> $past(COUNTER_O) == '0)
    else $error("down event not after zero");
  cov_update: cover property (UPDATE_O);
  cov_dir_fall: cover property ($fell(DIR_O));
  cov_back: cover property (req && !AVS_WAITREQUEST_O ##1 req);
endmodule : gttb_chk

bind gttb_top gttb_chk #(.CNT_W(CNT_W)) u_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .UPDATE_O(UPDATE_O), .DIR_O(DIR_O),
  .COUNTER_O(COUNTER_O));

/* test/gttb_tb_top.sv */
// Self-checking bench of the timer time base.
// Assumes an Avalon-MM slave that inserts up to 48 wait states per access.
module gttb_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK_I = 1'b0;
  logic NRST_I = 1'b0;
  logic [7:0] AVS_ADDRESS_I = 8'h00;
  logic AVS_READ_I = 1'b0;
  logic AVS_WRITE_I = 1'b0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0;
  logic [31:0] AVS_READDATA_O;
  logic AVS_WAITREQUEST_O;
  logic [3:0] ITI_I = 4'h0;
  logic CH0_PIN_I = 1'b0;
  logic CH1_PIN_I = 1'b0;
  logic ETI_I = 1'b0;
  logic UPDATE_O;
  logic DIR_O;
  logic [15:0] COUNTER_O;
  int fails = 0;
  int num_checks = 0;
  logic [7:0] ra [6] = '{gttb_pkg::OFS_PRESC, gttb_pkg::OFS_RELOAD, gttb_pkg::OFS_SLAVE,
    gttb_pkg::OFS_CTRL, gttb_pkg::OFS_EVGEN, 8'h40};
  logic [31:0] rw [6] = '{32'hffff, 32'hab, 32'hc077, 32'h12, 32'h0, 32'h5a5a};
  logic [31:0] rx [6] = '{32'hffff, 32'hab, 32'hc077, 32'h12, 32'h0, 32'h0};
  logic [15:0] sv [8] = '{16'h0007, 16'h0047, 16'h8057, 16'h0067, 16'h4000, 16'h0077,
    16'h0004, 16'h0001};
  int sk [8] = '{0, 1, 1, 3, 2, 2, 1, 0};
  logic [31:0] sx [8] = '{32'h3, 32'h6, 32'h3, 32'h3, 32'h3, 32'h3, 32'h38, 32'h3};

  gttb_top u_dut (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .ITI_I(ITI_I), .CH0_PIN_I(CH0_PIN_I),
    .CH1_PIN_I(CH1_PIN_I), .ETI_I(ETI_I), .UPDATE_O(UPDATE_O), .DIR_O(DIR_O),
    .COUNTER_O(COUNTER_O));

  initial
    forever #12.5 MCLK_I = ~MCLK_I;

  // ****
  // Helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Request holds until a rising edge samples waitrequest low; data is taken there
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n = 0;
    @(posedge MCLK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    do
    begin
      @(posedge MCLK_I);
      n++;
    end
    while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    q = AVS_READDATA_O;
    if (n >= 50)
      fails++;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic watch(input int n, output logic [31:0] dc, output logic [31:0] up,
    output logic [31:0] dt);
    logic [15:0] c0;
    logic d0;
    @(negedge MCLK_I);
    c0 = COUNTER_O;
    d0 = DIR_O;
    up = 0;
    dt = 0;
    repeat (n)
    begin
      @(negedge MCLK_I);
      up += (UPDATE_O === 1'b1);
      dt += (DIR_O !== d0);
      d0 = DIR_O;
    end
    dc = {16'h0, COUNTER_O - c0};
  endtask : watch

  task automatic drive(input int k, input logic v);
    case (k)
      0: ITI_I[0] <= v;
      1: CH0_PIN_I <= v;
      2: ETI_I <= v;
      default: CH1_PIN_I <= v;
    endcase
  endtask : drive

  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Whole run is under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge MCLK_I);
    fails++;
    complete_run();
  end

  // ****
  // Tests
  // ****
  initial
  begin
    logic [31:0] q;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [15:0] c0;
    repeat (3) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      wr(ra[i], rw[i]);
      bus(1'b0, ra[i], 32'h0, q);
      chk("register", rx[i], q);
    end
    $display("register table done");
    @(posedge MCLK_I);
    NRST_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    chk("reset count", 32'h0, {16'h0, COUNTER_O});
    chk("reset dir", 32'h0, {31'h0, DIR_O});
    bus(1'b0, gttb_pkg::OFS_RELOAD, 32'h0, q);
    chk("reset reload", {16'h0, gttb_pkg::RST_RELOAD}, q);
    $display("reset done");
    wr(gttb_pkg::OFS_RELOAD, 32'h80);
    wr(gttb_pkg::OFS_EVGEN, 32'h1);
    wr(gttb_pkg::OFS_CTRL, 32'h1);
    watch(8, a, b, c);
    chk("kernel steps", 32'h8, a);
    wr(gttb_pkg::OFS_PRESC, 32'h1);
    watch(8, a, b, c);
    chk("old divide", 32'h8, a);
    wr(gttb_pkg::OFS_EVGEN, 32'h1);
    @(negedge MCLK_I);
    chk("sw clear", 32'h1, {31'h0, COUNTER_O < 16'h0003});
    watch(8, a, b, c);
    chk("new divide", 32'h4, a);
    wr(gttb_pkg::OFS_CTRL, 32'h0);
    watch(8, a, b, c);
    chk("hold", 32'h0, a);
    $display("prescaler done");
    wr(gttb_pkg::OFS_RELOAD, 32'h3);
    wr(gttb_pkg::OFS_PRESC, 32'h0);
    wr(gttb_pkg::OFS_EVGEN, 32'h1);
    wr(gttb_pkg::OFS_CTRL, 32'h1);
    watch(40, a, b, c);
    chk("up events", 32'ha, b);
    bus(1'b0, gttb_pkg::OFS_STATUS, 32'h0, q);
    chk("flag", 32'h1, q);
    wr(gttb_pkg::OFS_CTRL, 32'h3);
    watch(40, a, b, c);
    chk("suppressed", 32'h0, b);
    wr(gttb_pkg::OFS_CTRL, 32'h11);
    watch(40, a, b, c);
    chk("down events", 32'ha, b);
    wr(gttb_pkg::OFS_CTRL, 32'h10);
    wr(gttb_pkg::OFS_EVGEN, 32'h1);
    @(negedge MCLK_I);
    chk("sw reload", 32'h3, {16'h0, COUNTER_O});
    wr(gttb_pkg::OFS_CTRL, 32'h0);
    wr(gttb_pkg::OFS_CTRL, 32'h20);
    wr(gttb_pkg::OFS_EVGEN, 32'h1);
    @(negedge MCLK_I);
    chk("center clear", 32'h0, {16'h0, COUNTER_O});
    wr(gttb_pkg::OFS_CTRL, 32'h21);
    watch(36, a, b, c);
    chk("center events", 32'hc, b);
    chk("center dir", 32'hc, c);
    $display("modes done");
    wr(gttb_pkg::OFS_CTRL, 32'h0);
    wr(gttb_pkg::OFS_RELOAD, 32'hffff);
    wr(gttb_pkg::OFS_EVGEN, 32'h1);
    wr(gttb_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wr(gttb_pkg::OFS_SLAVE, {16'h0, sv[i]});
      @(negedge MCLK_I);
      c0 = COUNTER_O;
      repeat (3)
      begin
        repeat (8) @(posedge MCLK_I);
        drive(sk[i], 1'b1);
        repeat (8) @(posedge MCLK_I);
        drive(sk[i], 1'b0);
      end
      repeat (8) @(posedge MCLK_I);
      @(negedge MCLK_I);
      chk("source", sx[i], {16'h0, COUNTER_O - c0});
    end
    $display("sources done");
    complete_run();
  end
endmodule : gttb_tb_top
